/* File: include/seg_pkg.sv */
package seg_pkg;

   // Sizes
   localparam int SEG_TASKS = 16;
   localparam int SEG_CHANS = 16;
   localparam int SEG_IDX_W = 4;
   localparam int SEG_INST_NUM = 6;

   // Register offsets inside one 4 kB instance window
   localparam int SEG_OFS_W = 12;
   localparam logic [11:0] SEG_OFS_TRIGGER = 12'h000;
   localparam logic [11:0] SEG_OFS_SUBSCRIBE = 12'h080;
   localparam logic [11:0] SEG_OFS_FLAG = 12'h100;
   localparam logic [11:0] SEG_OFS_PUBLISH = 12'h180;
   localparam logic [11:0] SEG_OFS_MASK = 12'h300;
   localparam logic [11:0] SEG_OFS_MASK_SET = 12'h304;
   localparam logic [11:0] SEG_OFS_MASK_CLR = 12'h308;
   localparam logic [11:0] SEG_OFS_SEEN = 12'h310;

   // Address field positions
   localparam int SEG_WORD_LSB = 2;
   localparam int SEG_REGION_LSB = 6;

   // Field positions
   localparam int SEG_CFG_EN_BIT = 31;
   localparam int SEG_CFG_IDX_LSB = 0;
   localparam int SEG_TRIG_BIT = 0;
   localparam int SEG_FLAG_BIT = 0;

   // Reset values
   localparam logic [15:0] SEG_RST_FLAGS = 16'h0000;
   localparam logic [15:0] SEG_RST_MASK = 16'h0000;
   localparam logic [15:0] SEG_RST_SEEN = 16'h0000;
   localparam logic [3:0] SEG_RST_IDX = 4'h0;

   // Instance bases, non-secure alias; the secure alias sits above it
   localparam logic [5:0][31:0] SEG_NS_BASE = {
      32'h4002_0000, 32'h4001_f000, 32'h4001_e000,
      32'h4001_d000, 32'h4001_c000, 32'h4001_b000};
   localparam logic [31:0] SEG_SEC_ALIAS = 32'h1000_0000;

   typedef struct packed {
      logic en;
      logic [3:0] idx;
   } seg_cfg_t;

   typedef seg_cfg_t [15:0] seg_cfg_arr_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] paddr;
      logic [31:0] pwdata;
   } seg_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } seg_apb_rsp_t;

   typedef enum logic [1:0] {
      SEG_ST_IDLE = 2'b01,
      SEG_ST_DONE = 2'b10
   } seg_apb_st_t;

   typedef struct packed {
      logic [15:0] flags;
      logic [15:0] mask;
      logic [15:0] seen;
      seg_cfg_arr_t sub;
      seg_cfg_arr_t pub;
      logic [15:0] chan_out;
      logic [31:0] rdata;
      logic slverr;
      seg_apb_st_t st;
   } seg_state_t;

endpackage

/* File: rtl/seg_sub_match.sv */
`timescale 1ns/100ps
module seg_sub_match (
   // Channel events from the interconnect
   input wire logic [15:0] chan_event,
   // Subscription configuration per task
   input wire seg_pkg::seg_cfg_arr_t cfg,
   // Task start requests
   output logic [15:0] hit
);

   genvar n;
   generate
      for (n = 0; n < seg_pkg::SEG_TASKS; n++) begin : g_task
         assign hit[n] = cfg[n].en & chan_event[cfg[n].idx];
      end
   endgenerate

endmodule

/* File: rtl/seg_pub_map.sv */
`timescale 1ns/100ps
module seg_pub_map (
   // Events generated this cycle
   input wire logic [15:0] fire,
   // Publication configuration per event
   input wire seg_pkg::seg_cfg_arr_t cfg,
   // Channel pulses to drive
   output logic [15:0] chan
);

   genvar c;
   generate
      for (c = 0; c < seg_pkg::SEG_CHANS; c++) begin : g_chan
         logic [15:0] src;
         genvar n;
         for (n = 0; n < seg_pkg::SEG_TASKS; n++) begin : g_src
            assign src[n] = fire[n] & cfg[n].en &
                            (cfg[n].idx == 4'(c));
         end
         // Several events may share one channel; they merge
         assign chan[c] = |src;
      end
   endgenerate

endmodule

/* File: rtl/seg_top.sv */
// Local design decision: the APB register port.
`timescale 1ns/100ps
module seg_top #(
   parameter int INST_SEL = 0
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire seg_pkg::seg_apb_req_t apb_req,
   output seg_pkg::seg_apb_rsp_t apb_rsp,
   // Peripheral interconnect channels
   input wire logic [15:0] chan_event_in,
   output logic [15:0] chan_event_out,
   // Interrupt
   output logic irq
);

   seg_pkg::seg_state_t s_r;
   seg_pkg::seg_state_t s_nxt;

   logic [11:0] ofs;
   logic [31:0] ns_base;
   logic [31:0] sec_base;
   logic inst_hit;
   logic aligned;
   logic [3:0] widx;
   logic [15:0] wsel;
   logic in_trig;
   logic in_sub;
   logic in_flag;
   logic in_pub;
   logic is_mask;
   logic is_set;
   logic is_clr;
   logic is_seen;
   logic mapped;
   logic access;
   logic done;
   logic wr_done;
   logic rd_done;
   logic [31:0] rd_word;
   logic [15:0] trig_wr;
   logic [15:0] flag_set;
   logic [15:0] flag_clr;
   logic [15:0] sub_hit;
   logic [15:0] fire;
   logic [15:0] chan_pub;

   // both aliases of this instance decode
   assign ns_base = seg_pkg::SEG_NS_BASE[INST_SEL];
   assign sec_base = ns_base + seg_pkg::SEG_SEC_ALIAS;
   assign inst_hit = (apb_req.paddr[31:12] == ns_base[31:12]) ||
                     (apb_req.paddr[31:12] == sec_base[31:12]);

   assign ofs = apb_req.paddr[11:0];
   assign aligned = (ofs[1:0] == 2'h0);
   assign widx = ofs[5:2];
   assign wsel = 16'h0001 << widx;

   // task block of sixteen words from zero
   assign in_trig = (ofs[11:6] == seg_pkg::SEG_OFS_TRIGGER[11:6]);
   assign in_sub = (ofs[11:6] == seg_pkg::SEG_OFS_SUBSCRIBE[11:6]);
   assign in_flag = (ofs[11:6] == seg_pkg::SEG_OFS_FLAG[11:6]);
   assign in_pub = (ofs[11:6] == seg_pkg::SEG_OFS_PUBLISH[11:6]);
   assign is_mask = (ofs == seg_pkg::SEG_OFS_MASK);
   assign is_set = (ofs == seg_pkg::SEG_OFS_MASK_SET);
   assign is_clr = (ofs == seg_pkg::SEG_OFS_MASK_CLR);
   assign is_seen = (ofs == seg_pkg::SEG_OFS_SEEN);

   assign mapped = inst_hit && aligned &&
                   (in_trig || in_sub || in_flag || in_pub ||
                    is_mask || is_set || is_clr || is_seen);

   // One wait state: data is latched first, pready follows
   assign access = apb_req.psel && apb_req.penable;
   assign done = access && (s_r.st == seg_pkg::SEG_ST_DONE);
   assign wr_done = done && apb_req.pwrite && mapped;
   assign rd_done = done && !apb_req.pwrite && mapped;

   // Read mux; the task words are write-only and read as zero
   always_comb begin
      rd_word = 32'h0000_0000;
      if (in_sub) begin
         rd_word[seg_pkg::SEG_CFG_EN_BIT] = s_r.sub[widx].en;
         rd_word[seg_pkg::SEG_CFG_IDX_LSB +: 4] = s_r.sub[widx].idx;
      end else if (in_pub) begin
         rd_word[seg_pkg::SEG_CFG_EN_BIT] = s_r.pub[widx].en;
         rd_word[seg_pkg::SEG_CFG_IDX_LSB +: 4] = s_r.pub[widx].idx;
      end else if (in_flag) begin
         rd_word[seg_pkg::SEG_FLAG_BIT] = s_r.flags[widx];
      end else if (is_mask || is_set || is_clr) begin
         // mask reads back from all three
         rd_word[15:0] = s_r.mask;
      end else if (is_seen) begin
         rd_word[15:0] = s_r.seen;
      end
   end

   // task n sets only flag n
   assign trig_wr = (wr_done && in_trig &&
                     apb_req.pwdata[seg_pkg::SEG_TRIG_BIT]) ?
                    wsel : 16'h0000;

   assign flag_set = (wr_done && in_flag &&
                      apb_req.pwdata[seg_pkg::SEG_FLAG_BIT]) ?
                     wsel : 16'h0000;
   assign flag_clr = (wr_done && in_flag &&
                      !apb_req.pwdata[seg_pkg::SEG_FLAG_BIT]) ?
                     wsel : 16'h0000;

   seg_sub_match u_sub (
      .chan_event(chan_event_in),
      .cfg(s_r.sub),
      .hit(sub_hit)
   );

   // software or subscribed channel fires event n
   assign fire = trig_wr | sub_hit;

   seg_pub_map u_pub (
      .fire(fire),
      .cfg(s_r.pub),
      .chan(chan_pub)
   );

   always_comb begin
      s_nxt = s_r;

      case (s_r.st)
         seg_pkg::SEG_ST_IDLE: begin
            if (access) begin
               s_nxt.st = seg_pkg::SEG_ST_DONE;
               s_nxt.rdata = mapped ? rd_word : 32'h0000_0000;
               s_nxt.slverr = !mapped;
            end
         end
         seg_pkg::SEG_ST_DONE: begin
            s_nxt.st = seg_pkg::SEG_ST_IDLE;
         end
         default: begin
            s_nxt.st = seg_pkg::SEG_ST_IDLE;
         end
      endcase

      if (wr_done) begin
         if (in_sub) begin
            s_nxt.sub[widx].en = apb_req.pwdata[seg_pkg::SEG_CFG_EN_BIT];
            s_nxt.sub[widx].idx =
               apb_req.pwdata[seg_pkg::SEG_CFG_IDX_LSB +: 4];
         end
         if (in_pub) begin
            s_nxt.pub[widx].en = apb_req.pwdata[seg_pkg::SEG_CFG_EN_BIT];
            s_nxt.pub[widx].idx =
               apb_req.pwdata[seg_pkg::SEG_CFG_IDX_LSB +: 4];
         end
         if (is_mask) begin
            s_nxt.mask = apb_req.pwdata[15:0];
         end
         if (is_set) begin
            s_nxt.mask = s_r.mask | apb_req.pwdata[15:0];
         end
         if (is_clr) begin
            s_nxt.mask = s_r.mask & ~apb_req.pwdata[15:0];
         end
      end

      // flag set wins over a same-cycle clear
      s_nxt.flags = (s_r.flags & ~flag_clr) | flag_set | fire;

      // Reading the seen register clears it; a new event still lands
      if (rd_done && is_seen) begin
         s_nxt.seen = fire;
      end else begin
         s_nxt.seen = s_r.seen | fire;
      end

      // Publish every generation, even if the flag was already set
      s_nxt.chan_out = chan_pub;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r.flags <= seg_pkg::SEG_RST_FLAGS;
         s_r.mask <= seg_pkg::SEG_RST_MASK;
         s_r.seen <= seg_pkg::SEG_RST_SEEN;
         for (int i = 0; i < seg_pkg::SEG_TASKS; i++) begin
            s_r.sub[i] <= '{en: 1'b0, idx: seg_pkg::SEG_RST_IDX};
            s_r.pub[i] <= '{en: 1'b0, idx: seg_pkg::SEG_RST_IDX};
         end
         s_r.chan_out <= 16'h0000;
         s_r.rdata <= 32'h0000_0000;
         s_r.slverr <= 1'b0;
         s_r.st <= seg_pkg::SEG_ST_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign apb_rsp.prdata = s_r.rdata;
   assign apb_rsp.pslverr = s_r.slverr && (s_r.st == seg_pkg::SEG_ST_DONE);
   assign apb_rsp.pready = (s_r.st == seg_pkg::SEG_ST_DONE);

   assign chan_event_out = s_r.chan_out;

   assign irq = |(s_r.flags & s_r.mask);

endmodule

/* File: dv/seg_far_model.sv */
`timescale 1ns/100ps
module seg_far_model (
   // Clock
   input wire logic pclk,
   // Interconnect channels
   input wire logic [15:0] chan_event_out,
   output logic [15:0] chan_event_in,
   // Published pulses collected
   output logic [15:0] got
);
   initial begin
      chan_event_in = 16'h0;
      got = 16'h0;
   end
   // Pulses last one cycle, so only an accumulator can catch them
   always @(posedge pclk) begin
      got <= got | chan_event_out;
   end
   task automatic pulse(input int c);
      @(posedge pclk);
      chan_event_in <= 16'h1 << c;
      @(posedge pclk);
      chan_event_in <= 16'h0;
   endtask
endmodule

/* File: dv/seg_top_asserts.sv */
`timescale 1ns/100ps
module seg_top_asserts (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bus and channels
   input wire seg_pkg::seg_apb_req_t apb_req,
   input wire seg_pkg::seg_apb_rsp_t apb_rsp,
   input wire logic [15:0] chan_event_in,
   input wire logic [15:0] chan_event_out,
   input wire logic irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic acc, rdone, wdone;
   assign acc = apb_req.psel & apb_req.penable;
   assign rdone = acc & !apb_req.pwrite & apb_rsp.pready;
   assign wdone = acc & apb_req.pwrite & apb_rsp.pready;
   property p_ready_pulse;
      apb_rsp.pready |=> !apb_rsp.pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready long");
   property p_one_wait;
      acc & !apb_rsp.pready |=> apb_rsp.pready;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("pready late");
   property p_err_ready;
      apb_rsp.pslverr |-> apb_rsp.pready;
   endproperty
   a_err_ready: assert property (p_err_ready) else $error("stray pslverr");
   property p_misalign;
      acc & apb_rsp.pready & apb_req.paddr[1:0] != 2'h0 |-> apb_rsp.pslverr;
   endproperty
   a_misalign: assert property (p_misalign) else $error("misaligned ok");
   property p_trig_rd0;
      rdone & apb_req.paddr[11:6] == 6'h0 |-> apb_rsp.prdata == 32'h0;
   endproperty
   a_trig_rd0: assert property (p_trig_rd0) else $error("trig read");
   property p_cfg_rd;
      rdone & (apb_req.paddr[11:7] == 5'h1 || apb_req.paddr[11:7] == 5'h3)
         |-> apb_rsp.prdata[30:4] == 27'h0;
   endproperty
   a_cfg_rd: assert property (p_cfg_rd) else $error("cfg bits");
   property p_pub_cause;
      chan_event_out != 16'h0 |-> $past(wdone) || $past(chan_event_in != 16'h0);
   endproperty
   a_pub_cause: assert property (p_pub_cause) else $error("stray pub");
   property p_irq_rise;
      $rose(irq) |-> $past(wdone) || $past(chan_event_in != 16'h0);
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("stray irq");
   property p_irq_fall;
      $fell(irq) |-> $past(wdone);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq dropped");
   c_wr: cover property (wdone);
   c_irq: cover property ($rose(irq));
   c_pub: cover property (chan_event_out != 16'h0);
endmodule
bind seg_top seg_top_asserts u_chk (.pclk(pclk), .presetn(presetn),
   .apb_req(apb_req), .apb_rsp(apb_rsp), .chan_event_in(chan_event_in),
   .chan_event_out(chan_event_out), .irq(irq));

/* File: dv/seg_top_tb.sv */
`timescale 1ns/100ps
module seg_top_tb;
   localparam logic [31:0] BASE = 32'h4001_c000;
   logic pclk, presetn, irq, err;
   seg_pkg::seg_apb_req_t req;
   seg_pkg::seg_apb_rsp_t rsp;
   logic [15:0] ch_in, ch_out, got;
   logic [31:0] rdv;
   int fails, checks_done;
   seg_top #(.INST_SEL(1)) dut (.pclk(pclk), .presetn(presetn),
      .apb_req(req), .apb_rsp(rsp), .chan_event_in(ch_in),
      .chan_event_out(ch_out), .irq(irq));
   seg_far_model far (.pclk(pclk), .chan_event_out(ch_out),
      .chan_event_in(ch_in), .got(got));
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   task automatic give_verdict;
      if (fails == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [31:0] e, s);
      checks_done++;
      if (s !== e) begin
         fails++;
         $display("ERROR %s exp %h got %h", nm, e, s);
      end
   endtask
   // Request holds until the rising edge that sees pready high
   task automatic apb(input logic w, input logic [31:0] a, d);
      int n;
      n = 0;
      @(posedge pclk);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      req.penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         fails++;
         give_verdict();
      end
      rdv = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a, e, input string nm);
      apb(1'b0, a, 32'h0);
      cmp(nm, e, rdv);
   endtask
   task automatic chk_irq(input logic e);
      @(negedge pclk);
      cmp("irq", {31'h0, e}, {31'h0, irq});
   endtask
   task automatic s_reset;
      rd(BASE + 32'h300, 32'h0, "mask");
      rd(BASE + 32'h13c, 32'h0, "flag15");
      chk_irq(1'b0);
   endtask
   task automatic s_trig;
      for (int n = 0; n < 16; n++) begin
         apb(1'b1, BASE + 32'(4 * n), 32'h1);
         rd(BASE + 32'h100 + 32'(4 * n), 32'h1, "flag");
         rd(BASE + 32'h100 + 32'(4 * ((n + 1) % 16)), 32'h0, "nbr");
         rd(BASE + 32'(4 * n), 32'h0, "trig");
         apb(1'b1, BASE + 32'h100 + 32'(4 * n), 32'h0);
      end
   endtask
   task automatic s_mask;
      rd(BASE + 32'h310, 32'hffff, "seen");
      rd(BASE + 32'h310, 32'h0, "seen2");
      apb(1'b1, BASE + 32'h300, 32'hffff_ffff);
      rd(BASE + 32'h304, 32'hffff, "mask");
      apb(1'b1, BASE + 32'h308, 32'hfe);
      rd(BASE + 32'h308, 32'hff01, "mclr");
      apb(1'b1, BASE + 32'h304, 32'h10);
      rd(BASE + 32'h300, 32'hff11, "mset");
      apb(1'b1, BASE + 32'h004, 32'h1);
      chk_irq(1'b0);
      apb(1'b1, BASE + 32'h304, 32'h2);
      chk_irq(1'b1);
      apb(1'b1, BASE + 32'h308, 32'h2);
      chk_irq(1'b0);
      apb(1'b1, BASE + 32'h304, 32'h2);
      apb(1'b1, BASE + 32'h104, 32'h0);
      chk_irq(1'b0);
   endtask
   task automatic s_pubsub;
      apb(1'b1, BASE + 32'h08c, 32'h5);
      far.pulse(5);
      rd(BASE + 32'h10c, 32'h0, "nosub");
      apb(1'b1, BASE + 32'h08c, 32'h8fff_fff5);
      apb(1'b1, BASE + 32'h18c, 32'h8000_000a);
      rd(BASE + 32'h08c, 32'h8000_0005, "sub");
      far.pulse(5);
      rd(BASE + 32'h10c, 32'h1, "subflag");
      cmp("pub", 32'h400, {16'h0, got});
      apb(1'b1, BASE + 32'h18c, 32'h8000_000c);
      apb(1'b1, BASE + 32'h00c, 32'h1);
      rd(BASE + 32'h18c, 32'h8000_000c, "pubcfg");
      cmp("pub2", 32'h1400, {16'h0, got});
   endtask
   task automatic s_alias;
      rd(BASE + 32'h1000_0300, 32'hff13, "sec");
      apb(1'b0, BASE + 32'h1000, 32'h0);
      cmp("other", 32'h1, {31'h0, err});
      apb(1'b0, BASE + 32'h302, 32'h0);
      cmp("misal", 32'h1, {31'h0, err});
      apb(1'b1, BASE + 32'h400, 32'h0);
      cmp("unmap", 32'h1, {31'h0, err});
   endtask
   initial begin
      req = '0;
      presetn = 1'b0;
      fails = 0;
      checks_done = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      s_reset();
      s_trig();
      s_mask();
      s_pubsub();
      s_alias();
      give_verdict();
   end
endmodule
